// ==== bench/test_dma_error_flag_interrupt.sv ====
// testbench: register, missed-event, queue and interrupt checks of the dma error block
`timescale 1ns/1ps
`default_nettype none
module test_dma_error_flag_interrupt;
   // ---------------------------------------------------------------------
   // signals and bench state
   // ---------------------------------------------------------------------
   localparam logic [3:0] A_LO = dmaerr_pkg::ADDR_DMA_MISSED_FLAGS_LOW;
   localparam logic [3:0] A_HI = dmaerr_pkg::ADDR_DMA_MISSED_FLAGS_HIGH;
   localparam logic [3:0] A_QF = dmaerr_pkg::ADDR_QDMA_MISSED_FLAGS;
   localparam logic [3:0] A_QC = dmaerr_pkg::ADDR_QDMA_MISSED_CLEAR;
   localparam logic [3:0] A_CE = dmaerr_pkg::ADDR_CONTROLLER_ERROR_FLAGS;
   localparam logic [3:0] A_CC = dmaerr_pkg::ADDR_CONTROLLER_ERROR_CLEAR;
   localparam logic [3:0] A_EV = dmaerr_pkg::ADDR_ERROR_REEVALUATE;
   localparam logic [3:0] A_TH = dmaerr_pkg::ADDR_QUEUE_THRESHOLD_SETTING;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic [3:0] avs_address_in = 4'h0;
   logic avs_read_in = 1'b0;
   logic avs_write_in = 1'b0;
   logic [31:0] avs_writedata_in = 32'h0;
   logic [3:0] avs_byteenable_in = 4'hf;
   logic [31:0] avs_readdata_out;
   logic avs_waitrequest_out;
   logic [63:0] dma_evt [3] = '{default: '0};
   logic [63:0] dma_pend [3] = '{default: '0};
   logic [63:0] dma_null = 64'h0;
   logic [7:0] q_evt = 8'h0;
   logic [7:0] q_pend = 8'h0;
   logic [7:0] q_null = 8'h0;
   logic [4:0] q_cnt [4] = '{default: '0};
   logic [6:0] tcc = 7'h0;
   logic err_irq_out;
   logic irq_d = 1'b0;
   int failures = 0;
   int compares = 0;
   int irq_cnt = 0;
   integer seed = 84;
   logic [63:0] exp_dma = 64'h0;
   logic [7:0] exp_q = 8'h0;
   logic [31:0] rd;
   logic [4:0] thr [4];

   dmaerr_top uut (.clk_in(clk_in), .rst_in(rst_in), .avs_address_in(avs_address_in),
      .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
      .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
      .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
      .dma_evt_in(dma_evt), .dma_pending_in(dma_pend), .dma_null_in(dma_null),
      .qdma_evt_in(q_evt), .qdma_pending_in(q_pend), .qdma_null_in(q_null),
      .queue_count_in(q_cnt), .tcc_outstanding_in(tcc), .err_irq_out(err_irq_out));

   initial begin
      forever #2 clk_in = ~clk_in;
   end

   // ---------------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------------
   function automatic logic [31:0] qstat(input logic exc, input logic [4:0] pk,
                                         input logic [4:0] cnt);
      return {7'h0, exc, 3'h0, pk, 3'h0, cnt, 8'h0};
   endfunction

   task automatic print_verdict();
      if (failures == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge clk_in);
   endtask

   // one avalon transfer; request held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [3:0] adr, input logic [31:0] wd,
                      input logic [3:0] be);
      int n;
      n = 0;
      @(posedge clk_in);
      avs_address_in <= adr;
      avs_writedata_in <= wd;
      avs_byteenable_in <= be;
      avs_write_in <= wr;
      avs_read_in <= ~wr;
      do begin
         @(posedge clk_in);
         n++;
      end while (avs_waitrequest_out !== 1'b0 && n < 50);
      if (n >= 50) failures++;
      rd = avs_readdata_out;
      avs_write_in <= 1'b0;
      avs_read_in <= 1'b0;
   endtask

   task automatic wr(input logic [3:0] adr, input logic [31:0] wd);
      bus(1'b1, adr, wd, 4'hf);
   endtask

   task automatic rd_chk(input logic [3:0] adr, input logic [31:0] exp);
      bus(1'b0, adr, 32'h0, 4'hf);
      check(rd, exp);
   endtask

   task automatic irq_chk(input int base, input int want);
      idle(4);
      check(32'(irq_cnt - base), 32'(want));
   endtask

   task automatic dma_hit(input int s, input int ch, input logic pend, input logic nul);
      @(posedge clk_in);
      dma_evt[s][ch] <= 1'b1;
      dma_pend[s][ch] <= pend;
      dma_null[ch] <= nul;
      @(posedge clk_in);
      dma_evt[s][ch] <= 1'b0;
      dma_pend[s][ch] <= 1'b0;
      dma_null[ch] <= 1'b0;
      if (pend | nul) exp_dma[ch] = 1'b1;
      idle(4);
   endtask

   task automatic q_hit(input int ch, input logic pend, input logic nul);
      @(posedge clk_in);
      q_evt[ch] <= 1'b1;
      q_pend[ch] <= pend;
      q_null[ch] <= nul;
      @(posedge clk_in);
      q_evt <= 8'h0;
      q_pend <= 8'h0;
      q_null <= 8'h0;
      if (pend | nul) exp_q[ch] = 1'b1;
      idle(4);
   endtask

   // interrupt counter; a pulse never lasts two cycles here
   always @(posedge clk_in) begin
      if (err_irq_out === 1'b1) irq_cnt++;
      if (!rst_in && err_irq_out === 1'b1 && irq_d === 1'b1) check(32'h1, 32'h0);
      irq_d <= err_irq_out;
   end

   initial begin
      #100000;
      failures++;
      print_verdict();
   end

   // ---------------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------------
   initial begin
      int base;
      int r;
      logic [31:0] m;
      repeat (6) @(posedge clk_in);
      rst_in <= 1'b0;
      rd_chk(A_LO, 32'h0);
      rd_chk(A_QF, 32'h0);
      rd_chk(A_CE, 32'h0);
      rd_chk(A_TH, 32'h10101010);
      rd_chk(dmaerr_pkg::ADDR_DMA_MISSED_CLEAR_LOW, 32'h0);
      rd_chk(4'hf, dmaerr_pkg::UNMAPPED_READ);
      // dma missed events, random channels and sources
      base = irq_cnt;
      dma_hit(2, 40, 1'b1, 1'b0);
      irq_chk(base, 1);
      dma_hit(0, 7, 1'b0, 1'b0);
      for (int i = 0; i < 14; i++) begin
         r = $random(seed);
         dma_hit((r & 32'hff) % 3, (r >>> 8) & 63, r[20], r[21] & r[22]);
      end
      irq_chk(base, 1);
      rd_chk(A_LO, exp_dma[31:0]);
      rd_chk(A_HI, exp_dma[63:32]);
      bus(1'b1, dmaerr_pkg::ADDR_DMA_MISSED_CLEAR_LOW, 32'hffffffff, 4'h0);
      rd_chk(A_LO, exp_dma[31:0]);
      m = $random(seed);
      wr(dmaerr_pkg::ADDR_DMA_MISSED_CLEAR_LOW, m);
      exp_dma[31:0] = exp_dma[31:0] & ~m;
      rd_chk(A_LO, exp_dma[31:0]);
      m = $random(seed);
      wr(dmaerr_pkg::ADDR_DMA_MISSED_CLEAR_HIGH, m);
      exp_dma[63:32] = exp_dma[63:32] & ~m;
      rd_chk(A_HI, exp_dma[63:32]);
      wr(dmaerr_pkg::ADDR_DMA_MISSED_CLEAR_LOW, 32'hffffffff);
      wr(dmaerr_pkg::ADDR_DMA_MISSED_CLEAR_HIGH, 32'hffffffff);
      rd_chk(A_HI, 32'h0);
      // qdma missed events after all errors were cleared
      base = irq_cnt;
      q_hit(3, 1'b1, 1'b0);
      irq_chk(base, 1);
      q_hit(6, 1'b0, 1'b1);
      q_hit(5, 1'b0, 1'b0);
      irq_chk(base, 1);
      wr(A_QF, 32'hffffffff);
      rd_chk(A_QF, {24'h0, exp_q});
      wr(A_EV, 32'h0);
      irq_chk(base, 1);
      wr(A_EV, 32'h1); // reserved bits written as zero
      irq_chk(base, 2);
      // hardware set held across the clearing write edge
      @(posedge clk_in);
      q_null[3] <= 1'b1;
      // the set is dropped right after the taking edge, so only set-wins keeps the flag
      fork
         wr(A_QC, 32'h08);
         begin
            idle(2);
            q_null <= 8'h0;
         end
      join
      idle(3);
      rd_chk(A_QF, {24'h0, exp_q});
      wr(A_QC, 32'h40);
      rd_chk(A_QF, 32'h08);
      wr(A_QC, 32'hff);
      rd_chk(A_QF, 32'h0);
      base = irq_cnt;
      wr(A_EV, 32'h1);
      irq_chk(base, 0);
      // queue thresholds at the boundary, sticky errors, watermark clear
      for (int n = 0; n < 4; n++) begin
         r = $random(seed);
         thr[n] = 5'((r & 32'hff) % 15 + 1);
      end
      wr(A_TH, {3'h0, thr[3], 3'h0, thr[2], 3'h0, thr[1], 3'h0, thr[0]});
      rd_chk(A_TH, {3'h0, thr[3], 3'h0, thr[2], 3'h0, thr[1], 3'h0, thr[0]});
      for (int n = 0; n < 4; n++) begin
         @(posedge clk_in);
         q_cnt[n] <= thr[n] - 5'h1;
         idle(4);
         rd_chk(A_CE, 32'h0);
         base = irq_cnt;
         q_cnt[n] <= thr[n];
         idle(4);
         rd_chk(dmaerr_pkg::ADDR_QUEUE_STATUS0 + 4'(n), qstat(1'b1, thr[n], thr[n]));
         q_cnt[n] <= 5'h0;
         idle(4);
         irq_chk(base, 1);
         wr(A_CE, 32'h0);
         rd_chk(A_CE, 32'h1 << n);
         rd_chk(dmaerr_pkg::ADDR_QUEUE_STATUS0 + 4'(n), qstat(1'b1, thr[n], 5'h0));
         wr(A_CC, 32'h1 << n);
         rd_chk(A_CE, 32'h0);
         rd_chk(dmaerr_pkg::ADDR_QUEUE_STATUS0 + 4'(n), qstat(1'b0, 5'h0, 5'h0));
      end
      // outstanding completion requests around the limit of 63
      @(posedge clk_in);
      tcc <= 7'h3f;
      idle(4);
      rd_chk(A_CE, 32'h0);
      tcc <= 7'h40;
      idle(4);
      tcc <= 7'h0;
      rd_chk(A_CE, 32'h10000);
      wr(A_CC, 32'h0000000f);
      rd_chk(A_CE, 32'h10000);
      wr(A_CC, 32'h10000);
      rd_chk(A_CE, 32'h0);
      print_verdict();
   end
endmodule
`default_nettype wire

// ==== src/dmaerr_flag_bank.sv ====
// module: bank of sticky error flags, set wins over clear
`timescale 1ns/1ps
`default_nettype none
module dmaerr_flag_bank #(
   parameter int W = 8
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // set, clear and state
   dmaerr_flag_if.bank fl
);
   logic [W-1:0] flags_ff;
   assign fl.flags = flags_ff;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         flags_ff <= '0;
      end else begin
         flags_ff <= (flags_ff & ~fl.clr) | fl.set; // [RL18] [RL9]
      end
   end

   property p_set_holds;
      @(posedge clk_in) disable iff (rst_in)
      (fl.set != '0) |=> ((flags_ff & $past(fl.set)) == $past(fl.set));
   endproperty
   a_set_holds: assert property (p_set_holds) else $error("set flag was lost"); // [RL18]

   property p_sticky;
      @(posedge clk_in) disable iff (rst_in)
      (fl.clr == '0) |=> ((flags_ff & $past(flags_ff)) == $past(flags_ff));
   endproperty
   a_sticky: assert property (p_sticky) else $error("flag dropped without clear"); // [RL9]
endmodule
`default_nettype wire

// ==== src/dmaerr_flag_if.sv ====
// interface: set and clear vectors between the top and a sticky flag bank
`timescale 1ns/1ps
`default_nettype none
interface dmaerr_flag_if #(parameter int W = 8);
   logic [W-1:0] set;
   logic [W-1:0] clr;
   logic [W-1:0] flags;
   modport ctl (output set, output clr, input flags);
   modport bank (input set, input clr, output flags);
endinterface
`default_nettype wire

// ==== src/dmaerr_pkg.sv ====
// package: register map, field positions and reset values of the dma error block
// ---------------------------------------------------------------------------
// Overview of operation
// RL1: second qdma event before the first is serviced sets that channel's missed flag.
// RL2: qdma event hitting a null entry or null request also sets the missed flag.
// RL3: eight qdma missed flags read at bits 7..0; bits 31..8 read zero.
// RL4: writing one to low clear bit n clears dma missed flag n, channels 0..31.
// RL5: writing one to high clear bit n clears dma missed flag n+32.
// RL6: writing one to qdma clear bit n clears qdma flag n; zeros do nothing.
// RL7: queue threshold error n sets when queue count reaches its programmed threshold.
// RL8: completion-code error bit 16 sets when outstanding requests exceed 63.
// RL9: controller error flags are read-only, sticky, cleared only by the clear register.
// RL10: writing one to bit 16 of error clear clears the completion-code error.
// RL11: writing one to error clear bit n clears queue n error, watermark, exceeded.
// RL12: error interrupt asserts when any error bit becomes set in any error register.
// RL13: interrupt is regenerated only when errors go from all clear to some set.
// RL14: writing one to reevaluate bit 0 pulses interrupt if any error stays set.
// RL15: software writes zero to reserved bits of error, clear and evaluate registers.
// RL16: dma missed flag sets per trigger source on a second event or null entry.
// RL17: queue high watermark tracks the most entries seen since reset or clear.
// RL18: a hardware set beats a software clear of the same bit in one cycle.
// RL19: the error interrupt output is a single-clock pulse per event.
// ---------------------------------------------------------------------------
package dmaerr_pkg;
   // ------------------------------------------------------------------------
   // register word addresses (byte address / 4)
   // ------------------------------------------------------------------------
   localparam logic [3:0] ADDR_DMA_MISSED_FLAGS_LOW = 4'h0;
   localparam logic [3:0] ADDR_DMA_MISSED_FLAGS_HIGH = 4'h1;
   localparam logic [3:0] ADDR_DMA_MISSED_CLEAR_LOW = 4'h2;
   localparam logic [3:0] ADDR_DMA_MISSED_CLEAR_HIGH = 4'h3;
   localparam logic [3:0] ADDR_QDMA_MISSED_FLAGS = 4'h4;
   localparam logic [3:0] ADDR_QDMA_MISSED_CLEAR = 4'h5;
   localparam logic [3:0] ADDR_CONTROLLER_ERROR_FLAGS = 4'h6;
   localparam logic [3:0] ADDR_CONTROLLER_ERROR_CLEAR = 4'h7;
   localparam logic [3:0] ADDR_ERROR_REEVALUATE = 4'h8;
   localparam logic [3:0] ADDR_QUEUE_THRESHOLD_SETTING = 4'h9;
   localparam logic [3:0] ADDR_QUEUE_STATUS0 = 4'ha;
   // ------------------------------------------------------------------------
   // sizes and field positions
   // ------------------------------------------------------------------------
   localparam int NUM_DMA = 64;
   localparam int NUM_QDMA = 8;
   localparam int NUM_QUEUES = 4;
   localparam int NUM_SRC = 3;
   localparam int CNT_W = 5;
   localparam int TCC_W = 7;
   localparam logic [TCC_W-1:0] TCC_MAX = 7'h3f;
   localparam int POS_COMPLETION_CODE = 16;
   localparam int POS_REEVALUATE = 0;
   localparam int POS_QSTAT_EXCEEDED = 24;
   localparam int POS_QSTAT_PEAK = 16;
   localparam int POS_QSTAT_COUNT = 8;
   localparam int QTHR_STRIDE = 8;
   localparam logic [CNT_W-1:0] QTHR_RESET = 5'h10;
   localparam logic [31:0] RST_ZERO = 32'h0;
   localparam logic [31:0] UNMAPPED_READ = 32'h0;
endpackage

// ==== src/dmaerr_top.sv ====
// module: dma error capture, queue threshold checks and error interrupt pulse
//
// Decided for this implementation: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module dmaerr_top (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // avalon-mm slave
   input wire logic [3:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   // dma events and pending, one bit per channel, per trigger source; null entries one bit per channel for all sources
   input wire logic [dmaerr_pkg::NUM_DMA-1:0] dma_evt_in [dmaerr_pkg::NUM_SRC],
   input wire logic [dmaerr_pkg::NUM_DMA-1:0] dma_pending_in [dmaerr_pkg::NUM_SRC],
   input wire logic [dmaerr_pkg::NUM_DMA-1:0] dma_null_in,
   // qdma events
   input wire logic [dmaerr_pkg::NUM_QDMA-1:0] qdma_evt_in,
   input wire logic [dmaerr_pkg::NUM_QDMA-1:0] qdma_pending_in,
   input wire logic [dmaerr_pkg::NUM_QDMA-1:0] qdma_null_in,
   // queue occupancy and outstanding completion requests
   input wire logic [dmaerr_pkg::CNT_W-1:0] queue_count_in [dmaerr_pkg::NUM_QUEUES],
   input wire logic [dmaerr_pkg::TCC_W-1:0] tcc_outstanding_in,
   // error interrupt
   output logic err_irq_out
);
   localparam int NQ = dmaerr_pkg::NUM_QUEUES;

   // ------------------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------------------
   typedef enum logic [1:0] {
      DMAERR_IDLE = 2'b01,
      DMAERR_DONE = 2'b10
   } dmaerr_bus_t;

   dmaerr_bus_t bus_ff;
   logic req;
   logic wr_stb;
   logic [31:0] wmask;
   logic [31:0] wbits;

   assign req = avs_read_in | avs_write_in;
   // a write acts once, in the idle cycle; the answer cycle only drops waitrequest
   assign wr_stb = avs_write_in && (bus_ff == DMAERR_IDLE);
   assign wmask = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
                   {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
   assign wbits = avs_writedata_in & wmask;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         bus_ff <= DMAERR_IDLE;
      end else begin
         case (bus_ff)
            DMAERR_IDLE: begin
               if (req) begin
                  bus_ff <= DMAERR_DONE;
               end
            end
            DMAERR_DONE: begin
               bus_ff <= DMAERR_IDLE;
            end
            default: begin
               bus_ff <= DMAERR_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         avs_waitrequest_out <= 1'b1;
      end else begin
         avs_waitrequest_out <= !(req && (bus_ff == DMAERR_IDLE));
      end
   end

   function automatic logic wr_at(input logic [3:0] a, input logic stb,
                                  input logic [3:0] adr);
      wr_at = stb && (adr == a);
   endfunction

   // ------------------------------------------------------------------------
   // dma missed flags
   // ------------------------------------------------------------------------
   dmaerr_flag_if #(.W(dmaerr_pkg::NUM_DMA)) dma_fl ();
   dmaerr_flag_if #(.W(dmaerr_pkg::NUM_QDMA)) qdma_fl ();
   dmaerr_flag_if #(.W(NQ + 1)) cc_fl ();

   logic [dmaerr_pkg::NUM_DMA-1:0] dma_second;
   always_comb begin
      dma_second = '0;
      for (int s = 0; s < dmaerr_pkg::NUM_SRC; s++) begin
         dma_second = dma_second | (dma_evt_in[s] & dma_pending_in[s]); // [RL16]
      end
   end
   assign dma_fl.set = dma_second | dma_null_in; // [RL16]
   assign dma_fl.clr = {
      wr_at(dmaerr_pkg::ADDR_DMA_MISSED_CLEAR_HIGH, wr_stb, avs_address_in) ? wbits : 32'h0, // [RL5]
      wr_at(dmaerr_pkg::ADDR_DMA_MISSED_CLEAR_LOW, wr_stb, avs_address_in) ? wbits : 32'h0 // [RL4]
   };

   dmaerr_flag_bank #(.W(dmaerr_pkg::NUM_DMA)) u_dma_bank (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .fl(dma_fl)
   );

   // ------------------------------------------------------------------------
   // qdma missed flags
   // ------------------------------------------------------------------------
   assign qdma_fl.set = (qdma_evt_in & qdma_pending_in) // [RL1]
                      | qdma_null_in; // [RL2]
   assign qdma_fl.clr = wr_at(dmaerr_pkg::ADDR_QDMA_MISSED_CLEAR, wr_stb, avs_address_in)
                      ? wbits[dmaerr_pkg::NUM_QDMA-1:0] : 8'h0; // [RL6]

   dmaerr_flag_bank #(.W(dmaerr_pkg::NUM_QDMA)) u_qdma_bank (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .fl(qdma_fl)
   );

   // ------------------------------------------------------------------------
   // queue thresholds, watermarks, completion-code overflow
   // ------------------------------------------------------------------------
   logic [dmaerr_pkg::CNT_W-1:0] thr_ff [NQ];
   logic [dmaerr_pkg::CNT_W-1:0] peak_ff [NQ];
   logic [NQ-1:0] qexc_ff;
   logic [NQ-1:0] q_hit;
   logic cc_clr_wr;
   logic [NQ-1:0] q_clr;

   assign cc_clr_wr = wr_at(dmaerr_pkg::ADDR_CONTROLLER_ERROR_CLEAR, wr_stb, avs_address_in);
   assign q_clr = cc_clr_wr ? wbits[NQ-1:0] : 4'h0;

   always_comb begin
      for (int q = 0; q < NQ; q++) begin
         q_hit[q] = (queue_count_in[q] >= thr_ff[q]); // [RL7]
      end
   end

   assign cc_fl.set = {(tcc_outstanding_in > dmaerr_pkg::TCC_MAX), q_hit}; // [RL8] [RL7]
   assign cc_fl.clr = {cc_clr_wr & wbits[dmaerr_pkg::POS_COMPLETION_CODE], q_clr}; // [RL10] [RL11]

   dmaerr_flag_bank #(.W(NQ + 1)) u_cc_bank (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .fl(cc_fl)
   );

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         for (int q = 0; q < NQ; q++) begin
            thr_ff[q] <= dmaerr_pkg::QTHR_RESET;
         end
      end else if (wr_at(dmaerr_pkg::ADDR_QUEUE_THRESHOLD_SETTING, wr_stb, avs_address_in)) begin
         for (int q = 0; q < NQ; q++) begin
            thr_ff[q] <= wbits[q*dmaerr_pkg::QTHR_STRIDE +: dmaerr_pkg::CNT_W];
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         qexc_ff <= '0;
         for (int q = 0; q < NQ; q++) begin
            peak_ff[q] <= '0;
         end
      end else begin
         qexc_ff <= (qexc_ff & ~q_clr) | q_hit; // [RL11] [RL18]
         for (int q = 0; q < NQ; q++) begin
            // a clear restarts the watermark from the present count, not zero
            if (q_clr[q]) begin
               peak_ff[q] <= queue_count_in[q]; // [RL11]
            end else if (queue_count_in[q] > peak_ff[q]) begin
               peak_ff[q] <= queue_count_in[q]; // [RL17]
            end
         end
      end
   end

   // ------------------------------------------------------------------------
   // error interrupt
   // ------------------------------------------------------------------------
   logic any_err;
   logic any_err_ff;
   logic reeval_wr;

   assign any_err = (|dma_fl.flags) | (|qdma_fl.flags) | (|cc_fl.flags);
   assign reeval_wr = wr_at(dmaerr_pkg::ADDR_ERROR_REEVALUATE, wr_stb, avs_address_in)
                  && wbits[dmaerr_pkg::POS_REEVALUATE];

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         any_err_ff <= 1'b0;
         err_irq_out <= 1'b0;
      end else begin
         any_err_ff <= any_err;
         err_irq_out <= (any_err && !any_err_ff) // [RL12] [RL13] [RL19]
                      || (reeval_wr && any_err); // [RL14]
      end
   end

   // ------------------------------------------------------------------------
   // read data
   // ------------------------------------------------------------------------
   logic [31:0] rdata;
   always_comb begin
      rdata = dmaerr_pkg::UNMAPPED_READ;
      if (avs_address_in == dmaerr_pkg::ADDR_DMA_MISSED_FLAGS_LOW) begin
         rdata = dma_fl.flags[31:0];
      end else if (avs_address_in == dmaerr_pkg::ADDR_DMA_MISSED_FLAGS_HIGH) begin
         rdata = dma_fl.flags[63:32];
      end else if (avs_address_in == dmaerr_pkg::ADDR_QDMA_MISSED_FLAGS) begin
         rdata = {24'h0, qdma_fl.flags}; // [RL3]
      end else if (avs_address_in == dmaerr_pkg::ADDR_CONTROLLER_ERROR_FLAGS) begin
         rdata = {15'h0, cc_fl.flags[NQ], 12'h0, cc_fl.flags[NQ-1:0]};
      end else if (avs_address_in == dmaerr_pkg::ADDR_QUEUE_THRESHOLD_SETTING) begin
         for (int q = 0; q < NQ; q++) begin
            rdata[q*dmaerr_pkg::QTHR_STRIDE +: dmaerr_pkg::CNT_W] = thr_ff[q];
         end
      end else begin
         for (int q = 0; q < NQ; q++) begin
            if (avs_address_in == dmaerr_pkg::ADDR_QUEUE_STATUS0 + 4'(q)) begin
               rdata[dmaerr_pkg::POS_QSTAT_EXCEEDED] = qexc_ff[q];
               rdata[dmaerr_pkg::POS_QSTAT_PEAK +: dmaerr_pkg::CNT_W] = peak_ff[q];
               rdata[dmaerr_pkg::POS_QSTAT_COUNT +: dmaerr_pkg::CNT_W] = queue_count_in[q];
            end
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         avs_readdata_out <= dmaerr_pkg::RST_ZERO;
      end else if (avs_read_in && (bus_ff == DMAERR_IDLE)) begin
         avs_readdata_out <= rdata;
      end
   end

   // ------------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------------
   property p_irq_rise;
      @(posedge clk_in) disable iff (rst_in)
      (any_err && !any_err_ff) |=> err_irq_out;
   endproperty
   a_irq_rise: assert property (p_irq_rise) else $error("no irq on first error"); // [RL12]

   property p_irq_cause;
      @(posedge clk_in) disable iff (rst_in)
      err_irq_out |-> $past(any_err);
   endproperty
   a_irq_cause: assert property (p_irq_cause) else $error("irq without error"); // [RL13]

   property p_irq_pulse;
      @(posedge clk_in) disable iff (rst_in)
      (err_irq_out && !$past(reeval_wr)) |=> !err_irq_out || $past(reeval_wr);
   endproperty
   a_irq_pulse: assert property (p_irq_pulse) else $error("irq longer than a pulse"); // [RL19]

   property p_reeval;
      @(posedge clk_in) disable iff (rst_in)
      (reeval_wr && any_err) |=> err_irq_out;
   endproperty
   a_reeval: assert property (p_reeval) else $error("reevaluate did not pulse"); // [RL14]

   property p_tcc;
      @(posedge clk_in) disable iff (rst_in)
      (tcc_outstanding_in > dmaerr_pkg::TCC_MAX) |=> cc_fl.flags[NQ];
   endproperty
   a_tcc: assert property (p_tcc) else $error("completion error not set"); // [RL8]

   property p_qthr;
      @(posedge clk_in) disable iff (rst_in)
      (queue_count_in[0] >= thr_ff[0]) |=> (cc_fl.flags[0] && qexc_ff[0]);
   endproperty
   a_qthr: assert property (p_qthr) else $error("queue 0 threshold not flagged"); // [RL7]

   property p_qdma_set;
      @(posedge clk_in) disable iff (rst_in)
      (qdma_null_in[0] || (qdma_evt_in[0] && qdma_pending_in[0])) |=> qdma_fl.flags[0];
   endproperty
   a_qdma_set: assert property (p_qdma_set) else $error("qdma 0 miss not flagged"); // [RL1]

   property p_peak;
      @(posedge clk_in) disable iff (rst_in)
      !q_clr[0] |=> (peak_ff[0] >= $past(queue_count_in[0]));
   endproperty
   a_peak: assert property (p_peak) else $error("watermark below seen count"); // [RL17]

   property p_wait;
      @(posedge clk_in) disable iff (rst_in)
      (req && bus_ff == DMAERR_IDLE) |=> !avs_waitrequest_out;
   endproperty
   a_wait: assert property (p_wait) else $error("bus answer late");

   property p_clr_low;
      @(posedge clk_in) disable iff (rst_in)
      (wr_at(dmaerr_pkg::ADDR_DMA_MISSED_CLEAR_LOW, wr_stb, avs_address_in)
         && (dma_fl.set[31:0] == 32'h0))
      |=> ((dma_fl.flags[31:0] & $past(wbits)) == 32'h0);
   endproperty
   a_clr_low: assert property (p_clr_low) else $error("low missed flag not cleared"); // [RL4]

   property p_clr_high;
      @(posedge clk_in) disable iff (rst_in)
      (wr_at(dmaerr_pkg::ADDR_DMA_MISSED_CLEAR_HIGH, wr_stb, avs_address_in)
         && (dma_fl.set[63:32] == 32'h0))
      |=> ((dma_fl.flags[63:32] & $past(wbits)) == 32'h0);
   endproperty
   a_clr_high: assert property (p_clr_high) else $error("high missed flag not cleared"); // [RL5]

   property p_qdma_clr;
      @(posedge clk_in) disable iff (rst_in)
      (wr_at(dmaerr_pkg::ADDR_QDMA_MISSED_CLEAR, wr_stb, avs_address_in)
         && (qdma_fl.set == 8'h0))
      |=> ((qdma_fl.flags & $past(wbits[dmaerr_pkg::NUM_QDMA-1:0])) == 8'h0);
   endproperty
   a_qdma_clr: assert property (p_qdma_clr) else $error("qdma flag not cleared"); // [RL6]

   property p_tcc_clr;
      @(posedge clk_in) disable iff (rst_in)
      (cc_clr_wr && wbits[dmaerr_pkg::POS_COMPLETION_CODE] && !cc_fl.set[NQ])
      |=> !cc_fl.flags[NQ];
   endproperty
   a_tcc_clr: assert property (p_tcc_clr) else $error("completion error not cleared"); // [RL10]

   property p_q_clr;
      @(posedge clk_in) disable iff (rst_in)
      (q_clr[0] && !q_hit[0])
      |=> (!cc_fl.flags[0] && !qexc_ff[0] && (peak_ff[0] == $past(queue_count_in[0])));
   endproperty
   a_q_clr: assert property (p_q_clr) else $error("queue 0 clear incomplete"); // [RL11]

   c_irq: cover property (@(posedge clk_in) disable iff (rst_in) err_irq_out);
   c_reeval: cover property (@(posedge clk_in) disable iff (rst_in) reeval_wr && any_err);
   c_q_clr: cover property (@(posedge clk_in) disable iff (rst_in) q_clr != 4'h0);
   c_tcc: cover property (@(posedge clk_in) disable iff (rst_in) cc_fl.set[NQ]);
   c_clr_set: cover property (@(posedge clk_in) disable iff (rst_in)
      (dma_fl.set & dma_fl.clr) != '0);
endmodule
`default_nettype wire
